//--- verilog/cmpc_pkg.sv
/*
  Shared constants and carrier types for the dual comparator control block.
  Assumes a 32-bit AXI4-Lite register bus with byte address equal to four
  times the register index.
*/
package cmpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and register map
  localparam int          ADDR_W       = 16;
  localparam int          NUM_CMP      = 2;
  localparam logic [11:0] IDX_C2_MAIN  = 12'hF35;
  localparam logic [11:0] IDX_C2_EDGE  = 12'hF36;
  localparam logic [11:0] IDX_C2_MINUS = 12'hF37;
  localparam logic [11:0] IDX_C2_PLUS  = 12'hF38;
  localparam logic [11:0] IDX_C1_MAIN  = 12'hF39;
  localparam logic [11:0] IDX_C1_EDGE  = 12'hF3A;
  localparam logic [11:0] IDX_C1_MINUS = 12'hF3B;
  localparam logic [11:0] IDX_C1_PLUS  = 12'hF3C;
  localparam logic [11:0] IDX_MIRROR   = 12'hF3D;
  localparam logic [11:0] IDX_IRQ_FLAG = 12'hF3E;
  localparam logic [11:0] IDX_IRQ_EN   = 12'hF3F;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_ON     = 7;
  localparam int BIT_RESULT = 6;
  localparam int BIT_INV    = 4;
  localparam int BIT_HYS    = 1;
  localparam int BIT_SYNC   = 0;
  localparam int BIT_RISE   = 1;
  localparam int BIT_FALL   = 0;
  localparam int SEL_W      = 3;
  localparam int ROUTE_W    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Input select codes; route bit n closes the switch for code n
  localparam logic [2:0] SEL_GND      = 3'h7;
  localparam logic [2:0] SEL_FVR_TWO  = 3'h6;
  localparam logic [2:0] SEL_DAC      = 3'h5;
  localparam logic [2:0] SEL_PIN_ONE  = 3'h1;
  localparam logic [2:0] SEL_PIN_ZERO = 3'h0;
  localparam logic [7:0] PLUS_LIVE    = 8'hE3;
  localparam logic [7:0] MINUS_LIVE   = 8'hCF;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic             cmpOnBit;
    logic             cmpInvertSelect;
    logic             hysteresisEnable;
    logic             syncSelect;
    logic             riseIrqEnable;
    logic             fallIrqEnable;
    logic [SEL_W-1:0] minusInputSelect;
    logic [SEL_W-1:0] plusInputSelect;
  } cmpc_ctrl_t;

  typedef struct packed {
    logic               enable;
    logic               hysteresisEnable;
    logic [ROUTE_W-1:0] plusRoute;
    logic [ROUTE_W-1:0] minusRoute;
  } cmpc_ana_t;

  typedef struct packed {
    logic waveformShutdownSourceEnable;
    logic adcTriggerSelect;
    logic timerExternalResetSelect;
  } cmpc_route_t;

  localparam cmpc_ctrl_t CTRL_RESET = '0;
  localparam cmpc_ana_t  ANA_RESET  = '0;

endpackage

//--- verilog/cmpc_top.sv
/*
  Digital control of two comparators: polarity, result register, timer
  synchronised output, edge flags, input routing and trigger outputs, with
  an AXI4-Lite register slave. Assumes the analog core, the timer clock
  (already prescaled) and all other inputs are synchronous to clk.
*/
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - Sync mode latches result on timer falling edge
// - Latch uses prescaled timer clock input
// - Sync uses only the one shared timer clock
// - Rise and fall detectors set enabled flag
// - Flag cleared by write; new edge wins
// - Edges seen after polarity, even when disabled
// - Plus select decode: ground, buffer, DAC, pins
// - Minus select decode: ground, buffer, four pins
// - Disabled comparator opens every input switch
// - Active output with enable shuts waveform generator
// - Rising output starts one ADC conversion
// - Rising output resets selected even timer
// - Sync output freezes in sleep on system clock
// - Enabled set flag wakes device from sleep
// - Main control bit layout, all reset zero
// - Invert bit inverts, clear passes result
// - Disabled comparator raw output is zero
// - Result registered each cycle, readable twice
module cmpc_top
(
  // Clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       ce,
  // AXI4-Lite slave
  input  wire logic [cmpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [cmpc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Analog core, index 0 is comparator one
  input  wire logic [1:0]                 cmpRaw,
  output cmpc_pkg::cmpc_ana_t             anaCtrl [cmpc_pkg::NUM_CMP],
  // Timer and power
  input  wire logic                       tmrClkPre,
  input  wire logic                       tmrClkIsSys,
  input  wire logic                       sleepMode,
  // Routing selects from other peripherals
  input  wire cmpc_pkg::cmpc_route_t      routeSel [cmpc_pkg::NUM_CMP],
  // Outputs to peripherals
  output logic [1:0]                      gateOut,
  output logic [1:0]                      shutdownReq,
  output logic [1:0]                      adcTrig,
  output logic [1:0]                      timerRst,
  output logic [1:0]                      irqFlag,
  output logic                            wakeReq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [11:0] cmpBase(input logic two);
    return two ? cmpc_pkg::IDX_C2_MAIN : cmpc_pkg::IDX_C1_MAIN;
  endfunction

  function automatic logic [7:0] routeDecode(input logic on, input logic [2:0] sel,
                                             input logic [7:0] live);
    logic [7:0] oneHot;
    oneHot = 8'h01 << sel;
    return on ? (oneHot & live) : 8'h00;
  endfunction

  function automatic logic [11:0] regIdx(input logic [cmpc_pkg::ADDR_W-1:0] a);
    return a[13:2];
  endfunction

  function automatic logic mapped(input logic [cmpc_pkg::ADDR_W-1:0] a);
    return (a[15:14] == 2'h0) && (a[13:2] >= cmpc_pkg::IDX_C2_MAIN)
           && (a[13:2] <= cmpc_pkg::IDX_IRQ_EN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  cmpc_pkg::cmpc_ctrl_t        ctrlQ [cmpc_pkg::NUM_CMP];
  logic [1:0]                  resultQ;
  logic [1:0]                  prevQ;
  logic [1:0]                  syncLatchQ;
  logic                        tmrPrevQ;
  logic [1:0]                  flagQ;
  logic [1:0]                  irqEnQ;
  logic [cmpc_pkg::ADDR_W-1:0] awAddrQ;
  logic [7:0]                  wDataQ;
  logic                        wStrbQ;
  logic                        awHaveQ;
  logic                        wHaveQ;
  logic [1:0]                  riseEv;
  logic [1:0]                  fallEv;
  logic [1:0]                  edgeSet;
  logic                        tmrFall;
  logic                        syncRun;
  logic                        awTake;
  logic                        wTake;
  logic                        arTake;
  logic                        doWrite;
  logic                        wrEn;
  logic [11:0]                 wrIdx;
  logic [7:0]                  rdMux;
  logic                        rdCmp;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  assign awTake  = s_axi_awvalid & s_axi_awready;
  assign wTake   = s_axi_wvalid & s_axi_wready;
  assign arTake  = s_axi_arvalid & s_axi_arready;
  assign doWrite = awHaveQ & wHaveQ;
  assign wrIdx   = regIdx(awAddrQ);
  assign wrEn    = doWrite & wStrbQ & mapped(awAddrQ);
  // Comparator two owns the lower block of indices; no address bit splits them
  assign rdCmp   = (regIdx(s_axi_araddr) <= cmpc_pkg::IDX_C2_PLUS);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awHaveQ       <= 1'b0;
      wHaveQ        <= 1'b0;
      awAddrQ       <= '0;
      wDataQ        <= 8'h00;
      wStrbQ        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cmpc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (awTake)
      begin
        awAddrQ <= s_axi_awaddr;
      end
      if (wTake)
      begin
        wDataQ <= s_axi_wdata[7:0];
        wStrbQ <= s_axi_wstrb[0];
      end
      awHaveQ       <= (awHaveQ | awTake) & ~doWrite;
      wHaveQ        <= (wHaveQ | wTake) & ~doWrite;
      s_axi_awready <= ~(awHaveQ | awTake | doWrite) & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready  <= ~(wHaveQ | wTake | doWrite) & ~(s_axi_bvalid & ~s_axi_bready);
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddrQ) ? cmpc_pkg::RESP_OKAY : cmpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb
  begin
    rdMux = 8'h00;
    case (regIdx(s_axi_araddr))
      cmpc_pkg::IDX_C1_MAIN, cmpc_pkg::IDX_C2_MAIN:
      begin
        rdMux = {ctrlQ[rdCmp].cmpOnBit, resultQ[rdCmp], 1'b0,
                 ctrlQ[rdCmp].cmpInvertSelect, 2'h0,
                 ctrlQ[rdCmp].hysteresisEnable,
                 ctrlQ[rdCmp].syncSelect};
      end
      cmpc_pkg::IDX_C1_EDGE, cmpc_pkg::IDX_C2_EDGE:
        rdMux = {6'h00, ctrlQ[rdCmp].riseIrqEnable,
                 ctrlQ[rdCmp].fallIrqEnable};
      cmpc_pkg::IDX_C1_MINUS, cmpc_pkg::IDX_C2_MINUS:
        rdMux = {5'h00, ctrlQ[rdCmp].minusInputSelect};
      cmpc_pkg::IDX_C1_PLUS, cmpc_pkg::IDX_C2_PLUS:
        rdMux = {5'h00, ctrlQ[rdCmp].plusInputSelect};
      cmpc_pkg::IDX_MIRROR:   rdMux = {6'h00, resultQ[1], resultQ[0]};
      cmpc_pkg::IDX_IRQ_FLAG: rdMux = {6'h00, flagQ};
      cmpc_pkg::IDX_IRQ_EN:   rdMux = {6'h00, irqEnQ};
      default:                rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cmpc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (arTake)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= mapped(s_axi_araddr) ? {24'h00_0000, rdMux} : 32'h0000_0000;
        s_axi_rresp  <= mapped(s_axi_araddr) ? cmpc_pkg::RESP_OKAY : cmpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~arTake & ~(s_axi_rvalid & ~s_axi_rready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, same layout for both comparators
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrlQ[0] <= cmpc_pkg::CTRL_RESET;
      ctrlQ[1] <= cmpc_pkg::CTRL_RESET;
      irqEnQ   <= 2'h0;
    end
    else if (ce && wrEn)
    begin
      for (int c = 0; c < cmpc_pkg::NUM_CMP; c++)
      begin
        if (wrIdx == cmpBase(1'(c)))
        begin
          ctrlQ[c].cmpOnBit         <= wDataQ[cmpc_pkg::BIT_ON];
          ctrlQ[c].cmpInvertSelect  <= wDataQ[cmpc_pkg::BIT_INV];
          ctrlQ[c].hysteresisEnable <= wDataQ[cmpc_pkg::BIT_HYS];
          ctrlQ[c].syncSelect       <= wDataQ[cmpc_pkg::BIT_SYNC];
        end
        if (wrIdx == cmpBase(1'(c)) + 12'h001)
        begin
          ctrlQ[c].riseIrqEnable <= wDataQ[cmpc_pkg::BIT_RISE];
          ctrlQ[c].fallIrqEnable <= wDataQ[cmpc_pkg::BIT_FALL];
        end
        if (wrIdx == cmpBase(1'(c)) + 12'h002)
        begin
          ctrlQ[c].minusInputSelect <= wDataQ[2:0];
        end
        if (wrIdx == cmpBase(1'(c)) + 12'h003)
        begin
          ctrlQ[c].plusInputSelect <= wDataQ[2:0];
        end
      end
      if (wrIdx == cmpc_pkg::IDX_IRQ_EN)
      begin
        irqEnQ <= wDataQ[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result path and edges
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resultQ <= 2'h0;
      prevQ   <= 2'h0;
    end
    else if (ce)
    begin
      for (int c = 0; c < cmpc_pkg::NUM_CMP; c++)
      begin
        // Raw forced low when off, so toggling on or invert still makes edges
        resultQ[c] <= (ctrlQ[c].cmpOnBit & cmpRaw[c]) ^ ctrlQ[c].cmpInvertSelect;
      end
      prevQ <= resultQ;
    end
  end

  assign riseEv = resultQ & ~prevQ;
  assign fallEv = ~resultQ & prevQ;

  always_comb
  begin
    for (int c = 0; c < cmpc_pkg::NUM_CMP; c++)
    begin
      edgeSet[c] = (riseEv[c] & ctrlQ[c].riseIrqEnable)
                 | (fallEv[c] & ctrlQ[c].fallIrqEnable);
    end
  end

  // Software may also set a flag by writing one
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flagQ <= 2'h0;
    end
    else if (ce)
    begin
      flagQ <= ((wrEn && wrIdx == cmpc_pkg::IDX_IRQ_FLAG) ? wDataQ[1:0] : flagQ)
               | edgeSet;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer synchronised output
  // One shared timer clock; other odd timers must run from it to be in step
  assign tmrFall = tmrPrevQ & ~tmrClkPre;
  assign syncRun = ~(sleepMode & tmrClkIsSys);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tmrPrevQ   <= 1'b0;
      syncLatchQ <= 2'h0;
    end
    else if (ce)
    begin
      tmrPrevQ <= tmrClkPre;
      for (int c = 0; c < cmpc_pkg::NUM_CMP; c++)
      begin
        // Falling edge capture keeps clear of the timer's rising count edge
        if (ctrlQ[c].syncSelect && tmrFall && syncRun)
        begin
          syncLatchQ[c] <= resultQ[c];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gateOut     <= 2'h0;
      shutdownReq <= 2'h0;
      adcTrig     <= 2'h0;
      timerRst    <= 2'h0;
      irqFlag     <= 2'h0;
      wakeReq     <= 1'b0;
      anaCtrl[0]  <= cmpc_pkg::ANA_RESET;
      anaCtrl[1]  <= cmpc_pkg::ANA_RESET;
    end
    else if (ce)
    begin
      for (int c = 0; c < cmpc_pkg::NUM_CMP; c++)
      begin
        gateOut[c]     <= ctrlQ[c].syncSelect ? syncLatchQ[c] : resultQ[c];
        shutdownReq[c] <= resultQ[c] & routeSel[c].waveformShutdownSourceEnable;
        adcTrig[c]     <= riseEv[c] & routeSel[c].adcTriggerSelect;
        timerRst[c]    <= riseEv[c] & routeSel[c].timerExternalResetSelect;
        anaCtrl[c].enable           <= ctrlQ[c].cmpOnBit;
        anaCtrl[c].hysteresisEnable <= ctrlQ[c].hysteresisEnable;
        anaCtrl[c].plusRoute  <= routeDecode(ctrlQ[c].cmpOnBit, ctrlQ[c].plusInputSelect,
                                             cmpc_pkg::PLUS_LIVE);
        anaCtrl[c].minusRoute <= routeDecode(ctrlQ[c].cmpOnBit, ctrlQ[c].minusInputSelect,
                                             cmpc_pkg::MINUS_LIVE);
      end
      irqFlag <= flagQ;
      wakeReq <= |(flagQ & irqEnQ);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_sync_latch_capture: assert property (ce && ctrlQ[0].syncSelect && tmrFall && syncRun
    |=> syncLatchQ[0] == $past(resultQ[0])) else $error("sync latch missed result");
  a_sync_sleep_hold: assert property (ce && sleepMode && tmrClkIsSys
    |=> $stable(syncLatchQ)) else $error("sync latch moved in sleep");
  a_rise_sets_flag: assert property (ce && riseEv[0] && ctrlQ[0].riseIrqEnable
    |=> flagQ[0]) else $error("rise did not set flag");
  a_set_beats_clear: assert property (ce && edgeSet[1] && wrEn && wrIdx == cmpc_pkg::IDX_IRQ_FLAG
    |=> flagQ[1]) else $error("edge lost against clear");
  a_off_follows_inv: assert property (ce && !ctrlQ[0].cmpOnBit
    |=> resultQ[0] == $past(ctrlQ[0].cmpInvertSelect)) else $error("off result wrong");
  a_off_routes_open: assert property (ce && !ctrlQ[1].cmpOnBit
    |=> anaCtrl[1].plusRoute == 8'h00 && anaCtrl[1].minusRoute == 8'h00)
    else $error("switch closed while off");
  a_plus_gnd_route: assert property (ce && ctrlQ[0].cmpOnBit
    && ctrlQ[0].plusInputSelect == cmpc_pkg::SEL_GND |=> anaCtrl[0].plusRoute == 8'h80)
    else $error("plus ground decode wrong");
  a_minus_gap_open: assert property (ce && ctrlQ[0].minusInputSelect == 3'h4
    |=> anaCtrl[0].minusRoute == 8'h00) else $error("minus gap code connected");
  a_adc_one_pulse: assert property (ce && adcTrig[0] && $past(ce) |-> !$past(adcTrig[0]))
    else $error("adc trigger longer than a pulse");
  a_shutdown_follow: assert property (ce && resultQ[0] && routeSel[0].waveformShutdownSourceEnable
    |=> shutdownReq[0]) else $error("shutdown not raised");
  a_wake_on_flag: assert property (ce && (flagQ & irqEnQ) != 2'h0 |=> wakeReq)
    else $error("wake not raised");

endmodule // cmpc_top

//--- bench/cmpc_far_model.sv
/*
  Far side of the comparator control block: analog levels, a prescaled
  timer clock and the timer and ADC that consume the outputs.
  Assumes it shares the block's clock and reset.
*/
`timescale 1ns/1ps

module cmpc_far_model
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Analog side
  input  wire logic [1:0]          level,
  output logic [1:0]               cmpRaw,
  // Timer and ADC side
  input  wire logic                tmrRun,
  input  wire logic [1:0]          gateOut,
  input  wire logic [1:0]          adcTrig,
  output logic                     tmrClkPre,
  output logic [7:0]               gateCount,
  output logic [7:0]               adcCount
);
  logic [1:0] divQ;
  logic       clkPrevQ;

  ////////////////////////////////////////
  // Raw result follows the bench's levels, even while disabled
  always_ff @(posedge clk)
    cmpRaw <= level;

  // Clock stands still while the timer is stopped
  always_ff @(posedge clk)
    if (reset)
      divQ <= 2'h0;
    else if (tmrRun)
      divQ <= divQ + 2'h1;

  assign tmrClkPre = divQ[1];

  ////////////////////////////////////////
  // Gated count on the rising edge, clear of the latch update
  always_ff @(posedge clk)
  begin
    clkPrevQ <= tmrClkPre;
    if (reset)
      gateCount <= 8'h00;
    else if (tmrClkPre && !clkPrevQ && gateOut[0])
      gateCount <= gateCount + 8'h01;
  end

  always_ff @(posedge clk)
    if (reset)
      adcCount <= 8'h00;
    else if (adcTrig[0])
      adcCount <= adcCount + 8'h01;
endmodule // cmpc_far_model

//--- bench/testbench.sv
/*
  Self-checking bench for the comparator control block.
  Assumes the far-side model and one 100 MHz clock.
*/
`timescale 1ns/1ps

module testbench;
  localparam logic [15:0] C1M = {2'b00, cmpc_pkg::IDX_C1_MAIN, 2'b00};
  localparam logic [15:0] C2M = {2'b00, cmpc_pkg::IDX_C2_MAIN, 2'b00};
  localparam logic [15:0] C1E = {2'b00, cmpc_pkg::IDX_C1_EDGE, 2'b00};
  localparam logic [15:0] C2E = {2'b00, cmpc_pkg::IDX_C2_EDGE, 2'b00};
  localparam logic [15:0] C1N = {2'b00, cmpc_pkg::IDX_C1_MINUS, 2'b00};
  localparam logic [15:0] C1P = {2'b00, cmpc_pkg::IDX_C1_PLUS, 2'b00};
  localparam logic [15:0] MIR = {2'b00, cmpc_pkg::IDX_MIRROR, 2'b00};
  localparam logic [15:0] FLG = {2'b00, cmpc_pkg::IDX_IRQ_FLAG, 2'b00};
  localparam logic [15:0] IEN = {2'b00, cmpc_pkg::IDX_IRQ_EN, 2'b00};
  localparam logic [1:0]  OK  = cmpc_pkg::RESP_OKAY;

  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic [15:0]           awaddr = 16'h0000;
  logic [15:0]           araddr = 16'h0000;
  logic [31:0]           wdata = 32'h00000000;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                  arvalid = 1'b0, rready = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid, wakeReq;
  logic [1:0]            bresp, rresp, gateOut, shutdownReq, adcTrig, timerRst;
  logic [1:0]            irqFlag, cmpRaw;
  logic [31:0]           rdata;
  logic                  tmrClkPre, tmrRun = 1'b0, sleepMode = 1'b0, tmrClkIsSys = 1'b0;
  logic [1:0]            level = 2'h0;
  logic [7:0]            gateCount, adcCount, rstCount = 8'h00;
  int                    mismatches = 0, testsRun = 0;
  cmpc_pkg::cmpc_ana_t   anaCtrl [cmpc_pkg::NUM_CMP];
  cmpc_pkg::cmpc_route_t routeSel [cmpc_pkg::NUM_CMP];

  always #5 clk = ~clk;

  cmpc_top u_dut (.clk(clk), .reset(reset), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmpRaw(cmpRaw), .anaCtrl(anaCtrl), .tmrClkPre(tmrClkPre), .tmrClkIsSys(tmrClkIsSys),
    .sleepMode(sleepMode), .routeSel(routeSel), .gateOut(gateOut), .shutdownReq(shutdownReq),
    .adcTrig(adcTrig), .timerRst(timerRst), .irqFlag(irqFlag), .wakeReq(wakeReq));

  cmpc_far_model u_far (.clk(clk), .reset(reset), .level(level), .cmpRaw(cmpRaw),
    .tmrRun(tmrRun), .gateOut(gateOut), .adcTrig(adcTrig), .tmrClkPre(tmrClkPre),
    .gateCount(gateCount), .adcCount(adcCount));

  always @(posedge clk)
    if (timerRst[0] === 1'b1)
      rstCount <= rstCount + 8'h01;

  ////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk({bvalid, bresp}, {1'b1, OK});
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] r);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk({rvalid, rresp, rdata}, {1'b1, r, 24'h000000, e});
  endtask

  ////////////////////////////////////////
  task automatic testReset;
    for (logic [11:0] i = 12'hF35; i <= 12'hF3F; i++)
      rd({2'b00, i, 2'b00}, 8'h00, OK);
    wr(MIR, 8'hFF);
    rd(MIR, 8'h00, OK);
    rd(16'h0000, 8'h00, cmpc_pkg::RESP_SLVERR);
    $display("reset and map test done");
  endtask

  task automatic testResult;
    wr(C1M, 8'h80);
    wr(C2M, 8'h80);
    level <= 2'b01;
    cyc(4);
    rd(C1M, 8'hC0, OK);
    rd(MIR, 8'h01, OK);
    wr(C1M, 8'h90);
    rd(C1M, 8'h90, OK);
    wr(C1M, 8'h10);
    rd(C1M, 8'h50, OK);
    level <= 2'b10;
    cyc(4);
    rd(MIR, 8'h03, OK);
    wr(C1M, 8'h00);
    wr(C2M, 8'h00);
    level <= 2'b00;
    $display("result test done");
  endtask

  task automatic testSelect;
    logic [7:0] pe, ne;
    wr(C1M, 8'h82);
    for (int c = 0; c < 8; c++)
    begin
      wr(C1P, 8'(c));
      wr(C1N, 8'(c));
      cyc(2);
      pe = (c < 2 || c > 4) ? 8'h01 << c : 8'h00;
      ne = (c == 4 || c == 5) ? 8'h00 : 8'h01 << c;
      chk({anaCtrl[0].plusRoute, anaCtrl[0].minusRoute}, {pe, ne});
    end
    chk(anaCtrl[0].hysteresisEnable, 1'b1);
    rd(C1P, 8'h07, OK);
    wr(C1M, 8'h00);
    cyc(2);
    chk({anaCtrl[0].enable, anaCtrl[0].plusRoute, anaCtrl[0].minusRoute}, 17'h0);
    $display("select test done");
  endtask

  task automatic testEdges;
    wr(C1M, 8'h80);
    wr(C1E, 8'h02);
    level <= 2'b01;
    cyc(5);
    chk(irqFlag, 2'b01);
    cyc(20);
    chk(irqFlag, 2'b01);
    wr(FLG, 8'h00);
    level <= 2'b00;
    cyc(5);
    chk(irqFlag, 2'b00);
    wr(C1E, 8'h01);
    level <= 2'b01;
    cyc(5);
    chk(irqFlag, 2'b00);
    level <= 2'b00;
    cyc(5);
    chk(irqFlag, 2'b01);
    wr(IEN, 8'h01);
    cyc(3);
    chk(wakeReq, 1'b1);
    wr(C1M, 8'h00);
    wr(FLG, 8'h00);
    cyc(3);
    chk({wakeReq, irqFlag}, 3'b000);
    wr(C1E, 8'h02);
    wr(C1M, 8'h10);
    cyc(5);
    chk(irqFlag, 2'b01);
    wr(C2M, 8'h80);
    wr(C2E, 8'h02);
    // Rise reaches the flag on the very edge the clear lands
    level <= 2'b10;
    wr(FLG, 8'h00);
    cyc(2);
    chk(irqFlag, 2'b10);
    wr(C1M, 8'h00);
    wr(C2M, 8'h00);
    wr(FLG, 8'h00);
    wr(IEN, 8'h00);
    $display("edge flag test done");
  endtask

  task automatic testRoute;
    logic [7:0] a0, r0;
    routeSel[0] <= 3'b111;
    wr(C1M, 8'h80);
    a0 = adcCount;
    r0 = rstCount;
    level <= 2'b01;
    cyc(6);
    chk({shutdownReq, adcCount - a0, rstCount - r0}, {2'b01, 8'h01, 8'h01});
    level <= 2'b00;
    cyc(6);
    chk({shutdownReq, adcCount - a0, rstCount - r0}, {2'b00, 8'h01, 8'h01});
    routeSel[0] <= 3'b000;
    level <= 2'b01;
    cyc(6);
    chk({shutdownReq, adcCount - a0, rstCount - r0}, {2'b00, 8'h01, 8'h01});
    level <= 2'b00;
    wr(C1M, 8'h00);
    $display("routing test done");
  endtask

  task automatic testSync;
    logic [7:0] g0;
    wr(C1M, 8'h81);
    tmrRun <= 1'b1;
    cyc(12);
    chk(gateOut, 2'b00);
    tmrRun <= 1'b0;
    level <= 2'b01;
    cyc(12);
    chk(gateOut, 2'b00);
    rd(C1M, 8'hC1, OK);
    tmrRun <= 1'b1;
    cyc(12);
    chk(gateOut, 2'b01);
    g0 = gateCount;
    cyc(16);
    chk({gateCount - g0}, 8'h04);
    sleepMode <= 1'b1;
    tmrClkIsSys <= 1'b1;
    level <= 2'b00;
    cyc(16);
    chk(gateOut, 2'b01);
    tmrClkIsSys <= 1'b0;
    cyc(16);
    chk(gateOut, 2'b00);
    sleepMode <= 1'b0;
    tmrRun <= 1'b0;
    wr(C1M, 8'h80);
    level <= 2'b01;
    cyc(4);
    chk(gateOut, 2'b01);
    $display("sync test done");
  endtask

  ////////////////////////////////////////
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    routeSel[0] = 3'b000;
    routeSel[1] = 3'b000;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    testReset;
    testResult;
    testSelect;
    testEdges;
    testRoute;
    testSync;
    giveVerdict;
  end

  // Tests need under a thousand cycles; allow twenty thousand
  initial
  begin
    #200000;
    mismatches++;
    $display("watchdog expired");
    giveVerdict;
  end
endmodule // testbench
